// ---- tb/abfc_dev_model.sv ----
// Behavioural pump interface unit on the far side of the host controller.
// Assumes bytes arrive on a valid/ready stream and leave as strobed bytes.
`timescale 1ns/1ps
module abfc_dev_model (
  // Clock
  input wire logic core_clk,
  // Bytes from the host
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  // Bytes to the host
  output logic rx_strobe,
  output logic [7:0] rx_data
);
  int nak_left = 0;
  bit mute = 1'b0;
  bit in_frm = 1'b0;
  bit end_seen = 1'b0;
  bit is_last = 1'b0;
  bit qry = 1'b0;
  bit wait_ack = 1'b0;
  int pos = 0;
  logic [7:0] acc = 8'hFF;
  logic [7:0] last_b = 8'h00;
  logic [7:0] sendq[$];

  // Idle lines at time zero
  initial
  begin
    tx_ready = 1'b0;
    rx_strobe = 1'b0;
    rx_data = 8'hFF;
  end

  // Random stalls so the skid buffer fills and refuses
  always @(posedge core_clk)
  begin
    #1;
    tx_ready = ($urandom % 16) > 5;
  end

  // Queue one reply block: start, digits, one character, end byte, checksum
  task automatic send_blk(input logic [7:0] num, input logic [7:0] c, input logic [7:0] endc);
    logic [7:0] b[$];
    logic [7:0] l;
    b = {8'h02, 8'h30, 8'h30, num, c, endc};
    l = 8'hFF;
    foreach (b[i])
      l = l ^ b[i];
    sendq = {sendq, b, l};
  endtask

  // Frame receiver: answers each block, then the reply frame after a final one
  always @(posedge core_clk)
  begin
    if (tx_valid && tx_ready)
    begin
      if (in_frm && end_seen) // Checksum slot first, so an LRC of 02 is no restart
      begin
        in_frm = 1'b0;
        if (!mute && (nak_left > 0 || (acc ^ tx_data) != 8'h00))
        begin
          sendq.push_back(8'h15);
          nak_left = (nak_left > 0) ? nak_left - 1 : 0;
        end
        else if (!mute) // Answer first, reply after
        begin
          sendq.push_back(8'h06);
          if (is_last && qry) // Query reply in two blocks
          begin
            send_blk(8'h31, 8'h23, 8'h17);
            wait_ack = 1'b1;
          end
          else if (is_last)
            send_blk(8'h31, 8'h23, 8'h03);
        end
      end
      else if (tx_data == 8'h02) // Restart on any start byte outside the checksum slot
      begin
        in_frm = 1'b1;
        end_seen = 1'b0;
        pos = 0;
        acc = 8'hFF ^ 8'h02;
      end
      else if (in_frm)
      begin
        acc = acc ^ tx_data;
        pos++;
        if (pos == 4 && (tx_data == 8'h3F || tx_data == 8'h20))
          qry = (tx_data == 8'h3F);
        end_seen = (tx_data == 8'h03) || (tx_data == 8'h17);
        is_last = (tx_data == 8'h03);
      end
      else if (wait_ack && tx_data == 8'h06) // Second block only after the host's answer
      begin
        wait_ack = 1'b0;
        send_blk(8'h32, 8'h37, 8'h03);
      end
    end
  end

  // Sender: data shows the inverse of the last byte once the strobe drops
  initial forever
  begin
    @(posedge core_clk);
    if (sendq.size() > 0)
    begin
      #1;
      last_b = sendq.pop_front();
      rx_data = last_b;
      rx_strobe = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      rx_strobe = 1'b0;
      rx_data = ~last_b;
      repeat (4) @(posedge core_clk);
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the host controller against a device model.
// Assumes the answer timeout parameter is shortened to 200 cycles.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_start = 1'b0;
  logic cmd_query = 1'b0;
  logic [7:0] cmd_func = 8'h00;
  logic [9:0] cmd_plen = 10'h000;
  logic par_valid = 1'b0;
  logic [7:0] par_data = 8'h00;
  wire logic par_ready, tx_valid, tx_ready, rx_strobe, rsp_valid, busy, done, fail;
  wire logic [7:0] tx_data, rx_data, rsp_data;
  int n_fail = 0;
  int compares = 0;
  logic [7:0] txq[$];
  logic [7:0] rspq[$];
  logic [7:0] pq[$];
  logic [1:0] evq[$];

  // Clock of 100 ns
  always #50 core_clk = ~core_clk;

  abfc_host #(.TIMEOUT_CYC(200)) u_abfc_host (.core_clk(core_clk), .resetn(resetn),
    .cmd_start(cmd_start), .cmd_query(cmd_query), .cmd_func(cmd_func), .cmd_plen(cmd_plen),
    .par_valid(par_valid), .par_data(par_data), .par_ready(par_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_strobe(rx_strobe), .rx_data(rx_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy), .done(done), .fail(fail));
  abfc_dev_model u_abfc_dev_model (.core_clk(core_clk), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_strobe(rx_strobe), .rx_data(rx_data));

  // Counting and reporting of one comparison
  task automatic note(input bit bad, input string msg);
    compares++;
    if (bad)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic cmp_tx(input logic [7:0] got);
    logic [7:0] e;
    e = (txq.size() > 0) ? txq.pop_front() : 8'hXX;
    note(got !== e, $sformatf("sent byte %h, expected %h", got, e));
  endtask

  task automatic cmp_rsp(input logic [7:0] got);
    logic [7:0] e;
    e = (rspq.size() > 0) ? rspq.pop_front() : 8'hXX;
    note(got !== e, $sformatf("reply byte %h, expected %h", got, e));
  endtask

  task automatic cmp_evt(input logic [1:0] got);
    logic [1:0] e;
    e = (evq.size() > 0) ? evq.pop_front() : 2'bXX;
    note(got !== e, $sformatf("fail/done %b, expected %b", got, e));
  endtask

  // Output watcher
  always @(posedge core_clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      cmp_tx(tx_data);
    if (rsp_valid === 1'b1)
      cmp_rsp(rsp_data);
    if (done === 1'b1 || fail === 1'b1)
      cmp_evt({fail, done});
  end

  function automatic logic [7:0] hexc(input int v);
    return 8'(v < 10 ? 48 + v : 55 + v);
  endfunction

  // Expected reply block from the device and the host's answer to it
  task automatic exp_rblk(input logic [7:0] num, input logic [7:0] c, input logic [7:0] endc);
    logic [7:0] b[$];
    logic [7:0] l;
    b = {8'h02, 8'h30, 8'h30, num, c, endc};
    l = 8'hFF;
    foreach (b[i])
      l = l ^ b[i];
    rspq = {rspq, b, l};
    txq.push_back(8'h06);
  endtask

  // Expected stream: blocks with digits, end byte and checksum, copies for resends
  task automatic exp_cmd(input bit q, input logic [7:0] f, input int p, input int tries);
    logic [7:0] body[$];
    logic [7:0] blk[$];
    logic [7:0] lrc;
    int nb;
    int n;
    pq = {};
    for (int i = 0; i < p; i++)
      pq.push_back(hexc($urandom % 16));
    body = {(q ? 8'h3F : 8'h20), f, pq};
    nb = (body.size() + 254) / 255;
    for (int b = 1; b <= nb; b++)
    begin
      blk = {8'h02, hexc(b / 100), hexc((b / 10) % 10), hexc(b % 10)};
      n = (b < nb) ? 255 : body.size() - 255 * (nb - 1);
      for (int i = 0; i < n; i++)
        blk.push_back(body[255 * (b - 1) + i]);
      blk.push_back((b < nb) ? 8'h17 : 8'h03);
      lrc = 8'hFF;
      foreach (blk[i])
        lrc = lrc ^ blk[i];
      blk.push_back(lrc);
      repeat ((b == 1) ? tries : 1) txq = {txq, blk};
      if (tries == 6)
        break;
    end
    if (tries == 6)
      evq.push_back(2'b10);
    else
    begin
      if (q)
      begin
        exp_rblk(8'h31, 8'h23, 8'h17);
        exp_rblk(8'h32, 8'h37, 8'h03);
      end
      else
        exp_rblk(8'h31, 8'h23, 8'h03);
      evq.push_back(2'b01);
    end
  endtask

  // One command: start, parameter feed, a stray start while busy, then drain
  task automatic run(input bit q, input logic [7:0] f, input int p, input int naks,
                     input bit mute);
    int t;
    logic [7:0] fr;
    fr = 8'(f + ($urandom % 8));
    u_abfc_dev_model.nak_left = naks;
    u_abfc_dev_model.mute = mute;
    exp_cmd(q, fr, p, (naks > 5 || mute) ? 6 : naks + 1);
    cmd_query = q;
    cmd_func = fr;
    cmd_plen = 10'(p);
    cmd_start = 1'b1;
    @(posedge core_clk);
    #1;
    cmd_start = 1'b0;
    foreach (pq[i])
    begin
      par_data = pq[i];
      par_valid = 1'b1;
      t = 0;
      do
      begin
        @(posedge core_clk);
        t++;
      end while (par_ready !== 1'b1 && t < 5000);
      #1;
      if ($urandom % 2)
      begin
        par_valid = 1'b0;
        @(posedge core_clk);
        #1;
      end
    end
    par_valid = 1'b0;
    cmd_start = (busy === 1'b1);
    @(posedge core_clk);
    #1;
    cmd_start = 1'b0;
    t = 0;
    while ((txq.size() + rspq.size() + evq.size()) > 0 && t < 20000)
    begin
      @(posedge core_clk);
      t++;
    end
    note(t >= 20000, "command did not complete");
    repeat (20) @(posedge core_clk);
    #1;
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: boundary lengths, resends, exhausted retries, silent device
  initial
  begin
    void'($urandom(52888));
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    run(1'b0, 8'h41, 1 + $urandom % 8, 0, 1'b0);
    run(1'b1, 8'h42, 300, 2, 1'b0);
    run(1'b0, 8'h43, 253, 0, 1'b0);
    run(1'b0, 8'h44, 254, 1, 1'b0);
    run(1'b1, 8'h45, 5, 6, 1'b0);
    run(1'b0, 8'h46, 4, 0, 1'b1);
    // Reset in the middle of a silent command; the device drops the cut frame
    u_abfc_dev_model.mute = 1'b1;
    exp_cmd(1'b0, 8'h48, 0, 1);
    cmd_query = 1'b0;
    cmd_func = 8'h48;
    cmd_plen = 10'h000;
    cmd_start = 1'b1;
    @(posedge core_clk);
    #1;
    cmd_start = 1'b0;
    repeat (40) @(posedge core_clk);
    #1;
    resetn = 1'b0;
    txq = {};
    rspq = {};
    evq = {};
    @(posedge core_clk);
    #1;
    resetn = 1'b1;
    @(posedge core_clk);
    #1;
    note({busy, tx_valid, rsp_valid, done, fail} !== 5'b00000, "outputs not idle after reset");
    run(1'b0, 8'h47, 509, 0, 1'b0);
    finish_test;
  end

  // Watchdog
  initial
  begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    finish_test;
  end
endmodule

// ---- verilog/abfc_buf2.sv ----
// Two-entry skid buffer for the outgoing byte stream.
// Assumes both sides run on core_clk.
`timescale 1ns/1ps
module abfc_buf2 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  // Draining side
  abfc_buf_if.src out
);
  logic [7:0] mem_r [2];
  logic [1:0] cnt_r;
  logic wptr_r;
  logic rptr_r;
  wire push = in_valid && in_ready;
  wire pop = out.valid && out.ready;
  // Status decode
  assign in_ready = (cnt_r != 2'd2);
  assign out.valid = (cnt_r != 2'd0);
  assign out.data = mem_r[rptr_r];
  // Storage and pointers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_r <= 2'd0;
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end
    else
    begin
      if (push) mem_r[wptr_r] <= in_data;
      if (push) wptr_r <= ~wptr_r;
      if (pop) rptr_r <= ~rptr_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  no_overflow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cnt_r == 2'd2 |-> !push) else $error("buffer written while full");
endmodule

// ---- verilog/abfc_buf_if.sv ----
// Valid/ready byte channel between the buffer and the transmit output register.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface abfc_buf_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/abfc_host.sv ----
// Host controller: frames one command message into blocks, sends each with
// checksum, waits for the answer byte, retries, then takes the reply frame.
// Assumes a UART outside: tx bytes leave on tx_*, received bytes arrive
// from the pin side on rx_* and are resynchronised here.
`timescale 1ns/1ps
// Functional notes
// - Control characters are fixed bytes 02 03 17 06 15 40.
// - A block is start, three digits, up to 255 characters, end, checksum.
// - Messages up to 255 characters go as block one ending in frame end.
// - Longer messages split; full blocks end block-end, last ends frame end.
// - Control messages start with space then function code then parameters.
// - Parameters are 16-bit signed values in hexadecimal ASCII.
// - Lead character and function code only in the first block.
// - Host acknowledges every reply frame before a new command.
// - Single-block parameter is under 254 characters.
// - Two-block parameter is under 509 characters.
// - Next block is sent only after a positive acknowledge.
// - Queries start with question mark, only in the first block.
// - Checksum starts at FF and XORs every preceding frame byte.
// - On negative acknowledge resend the same block, at most five times.
// - With no answer in two seconds resend the block.
module abfc_host #(
  parameter int TIMEOUT_CYC = abfc_pkg::ANS_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Command request: message body is lead, function code, parameters
  input wire logic cmd_start,
  input wire logic cmd_query,
  input wire logic [7:0] cmd_func,
  input wire logic [9:0] cmd_plen,
  input wire logic par_valid,
  input wire logic [7:0] par_data,
  output logic par_ready,
  // Transmit byte stream to the UART
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Received bytes from the UART (other domain)
  input wire logic rx_strobe,
  input wire logic [7:0] rx_data,
  // Reply and status
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic busy,
  output logic done,
  output logic fail
);
  abfc_buf_if bif ();
  abfc_pkg::abfc_state_e st_r, st_nxt;
  logic [9:0] left_r;
  logic [7:0] bcnt_r;
  logic [1:0] dig_r;
  logic [7:0] blkno_r;
  logic [7:0] lrc_r;
  logic last_r;
  logic [2:0] retry_r;
  logic [31:0] tmo_r;
  logic [7:0] hist_r [256];
  logic [7:0] hidx_r;
  logic replay_r;
  logic [7:0] blen_r;
  logic rend_r;
  logic [1:0] lead_r;
  logic query_r;
  logic [7:0] func_r;
  logic in_reply_r;
  logic s1_r, s2_r, s3_r;
  logic [7:0] d1_r, d2_r;
  logic tx_valid_r, rsp_valid_r, busy_r, done_r, fail_r;
  logic [7:0] tx_data_r, rsp_data_r;
  // Decimal digit of the block number for digit position d
  function automatic logic [7:0] num_digit(input logic [7:0] n, input logic [1:0] d);
    logic [7:0] q;
    q = (d == 2'd0) ? n / 8'd100 : (d == 2'd1) ? (n / 8'd10) % 8'd10 : n % 8'd10;
    return abfc_pkg::CH_DIGIT0 + q;
  endfunction
  // Byte offered to the buffer in each sending state
  wire rx_ev = s2_r && !s3_r;
  wire [7:0] rx_b = d2_r;
  wire msg_byte_ok = replay_r || lead_r != 2'd0 || par_valid;
  wire [7:0] msg_byte = replay_r ? hist_r[hidx_r] : (lead_r == 2'd2) ?
    (query_r ? abfc_pkg::CH_QUERY_LEAD : abfc_pkg::CH_CTRL_LEAD) :
    (lead_r == 2'd1) ? func_r : par_data;
  wire blk_full = bcnt_r == 8'(abfc_pkg::BLK_MSG_MAX);
  // A resend stops at the length of the block as first sent
  wire msg_done = replay_r ? (bcnt_r == blen_r) : (blk_full || (left_r == 10'd0));
  wire rx_end = (rx_b == abfc_pkg::CH_FRM_END) || (rx_b == abfc_pkg::CH_BLK_END);
  wire [7:0] end_ch = last_r ? abfc_pkg::CH_FRM_END : abfc_pkg::CH_BLK_END;
  wire [7:0] in_b =
    (st_r == abfc_pkg::ST_START) ? abfc_pkg::CH_BLK_START :
    (st_r == abfc_pkg::ST_NUM) ? num_digit(blkno_r, dig_r) :
    (st_r == abfc_pkg::ST_MSG) ? msg_byte :
    (st_r == abfc_pkg::ST_END) ? end_ch :
    (st_r == abfc_pkg::ST_LRC) ? lrc_r : abfc_pkg::CH_ACK;
  wire in_v = (st_r == abfc_pkg::ST_START) || (st_r == abfc_pkg::ST_NUM) ||
    (st_r == abfc_pkg::ST_END) || (st_r == abfc_pkg::ST_LRC) ||
    (st_r == abfc_pkg::ST_REPLY) || (st_r == abfc_pkg::ST_MSG && !msg_done && msg_byte_ok);
  logic in_rdy;
  wire take = in_v && in_rdy;
  wire take_par = take && st_r == abfc_pkg::ST_MSG && !replay_r && lead_r == 2'd0;
  wire tmo_hit = tmo_r >= 32'(TIMEOUT_CYC - 1);
  wire retry_ok = retry_r < 3'(abfc_pkg::MAX_RETRY);
  assign par_ready = st_r == abfc_pkg::ST_MSG && !replay_r && lead_r == 2'd0 &&
    !msg_done && in_rdy;
  // Buffer feeding the UART, so a stalled transmitter loses no byte
  abfc_buf2 u_buf (
    .core_clk(core_clk),
    .resetn(resetn),
    .in_valid(in_v),
    .in_data(in_b),
    .in_ready(in_rdy),
    .out(bif.src)
  );
  assign bif.ready = !tx_valid_r || tx_ready;
  // Next state of the framer
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      abfc_pkg::ST_IDLE: if (cmd_start) st_nxt = abfc_pkg::ST_START;
      abfc_pkg::ST_START: if (take) st_nxt = abfc_pkg::ST_NUM;
      abfc_pkg::ST_NUM: if (take && dig_r == 2'd2) st_nxt = abfc_pkg::ST_MSG;
      abfc_pkg::ST_MSG: if (msg_done) st_nxt = abfc_pkg::ST_END;
      abfc_pkg::ST_END: if (take) st_nxt = abfc_pkg::ST_LRC;
      abfc_pkg::ST_LRC: if (take) st_nxt = abfc_pkg::ST_WAIT;
      abfc_pkg::ST_WAIT:
        if (rx_ev && rx_b == abfc_pkg::CH_ACK)
          st_nxt = last_r ? abfc_pkg::ST_RESP : abfc_pkg::ST_START;
        else if ((rx_ev && rx_b == abfc_pkg::CH_NAK) || tmo_hit)
          st_nxt = retry_ok ? abfc_pkg::ST_START : abfc_pkg::ST_FAIL;
      abfc_pkg::ST_RESP:
        if (rx_ev && rend_r)  // Checksum byte after the end byte closes the block
          st_nxt = abfc_pkg::ST_REPLY;
        else if (tmo_hit) st_nxt = abfc_pkg::ST_FAIL;
      abfc_pkg::ST_REPLY: if (take) st_nxt = in_reply_r ? abfc_pkg::ST_IDLE : abfc_pkg::ST_RESP;
      abfc_pkg::ST_FAIL: st_nxt = abfc_pkg::ST_IDLE;
      default: st_nxt = abfc_pkg::ST_IDLE;
    endcase
  end
  // Receive synchroniser and toggle-free strobe edge
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn) {s1_r, s2_r, s3_r, d1_r, d2_r} <= '0;
    else {s1_r, s2_r, s3_r, d1_r, d2_r} <= {rx_strobe, s1_r, s2_r, rx_data, d1_r};
  end
  // Framer state, counters, checksum and block history
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= abfc_pkg::ST_IDLE;
      {left_r, bcnt_r, dig_r, blkno_r, lrc_r, last_r, retry_r, tmo_r} <= '0;
      {hidx_r, replay_r, lead_r, query_r, func_r, in_reply_r, blen_r, rend_r} <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      tmo_r <= (st_r == st_nxt && !rx_ev) ? tmo_r + 32'd1 : 32'd0;
      if (st_r == abfc_pkg::ST_IDLE && cmd_start)
      begin
        {query_r, func_r, lead_r, blkno_r, retry_r} <= {cmd_query, cmd_func, 2'd2, 8'd1, 3'd0};
        left_r <= cmd_plen + 10'd2;
        {replay_r, in_reply_r, rend_r} <= 3'b000;
      end
      if (st_r == abfc_pkg::ST_START && take)
      begin
        lrc_r <= abfc_pkg::LRC_INIT ^ in_b;
        {dig_r, bcnt_r, hidx_r} <= '0;
      end
      if (take && st_r != abfc_pkg::ST_START && st_r != abfc_pkg::ST_LRC) lrc_r <= lrc_r ^ in_b;
      if (take && st_r == abfc_pkg::ST_NUM) dig_r <= dig_r + 2'd1;
      if (take && st_r == abfc_pkg::ST_MSG)
      begin
        hidx_r <= hidx_r + 8'd1;
        bcnt_r <= bcnt_r + 8'd1;
        if (!replay_r) left_r <= left_r - 10'd1;
        if (lead_r != 2'd0 && !replay_r) lead_r <= lead_r - 2'd1;
      end
      if (st_r == abfc_pkg::ST_MSG && msg_done) last_r <= replay_r ? last_r : !blk_full ||
        left_r == 10'd0;
      if (st_r == abfc_pkg::ST_MSG && msg_done && !replay_r) blen_r <= bcnt_r;
      if (st_r == abfc_pkg::ST_WAIT && st_nxt == abfc_pkg::ST_START)
      begin
        replay_r <= !(rx_ev && rx_b == abfc_pkg::CH_ACK);
        if (rx_ev && rx_b == abfc_pkg::CH_ACK)
        begin
          blkno_r <= blkno_r + 8'd1;
          retry_r <= 3'd0;
        end
        else retry_r <= retry_r + 3'd1;
      end
      // Reply end byte arms the checksum slot, so an LRC equal to 03 or 17 is harmless
      if (st_r == abfc_pkg::ST_RESP && rx_ev)
        rend_r <= !rend_r && rx_end;
      if (st_r == abfc_pkg::ST_RESP && rx_ev && !rend_r && rx_end)
        in_reply_r <= rx_b == abfc_pkg::CH_FRM_END;
      if (replay_r && st_r == abfc_pkg::ST_MSG && hidx_r == bcnt_r && msg_done) replay_r <= 1'b0;
    end
  end
  // Block history for resends; plain storage without reset
  always_ff @(posedge core_clk)
  begin
    if (take && st_r == abfc_pkg::ST_MSG) hist_r[hidx_r] <= in_b;
  end
  // Registered outputs
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {tx_valid_r, tx_data_r, rsp_valid_r, rsp_data_r, busy_r, done_r, fail_r} <= '0;
    end
    else
    begin
      if (bif.ready)
      begin
        tx_valid_r <= bif.valid;
        tx_data_r <= bif.data;
      end
      rsp_valid_r <= st_r == abfc_pkg::ST_RESP && rx_ev;
      rsp_data_r <= rx_b;
      busy_r <= st_nxt != abfc_pkg::ST_IDLE;
      done_r <= st_r == abfc_pkg::ST_REPLY && take && in_reply_r;
      fail_r <= st_r == abfc_pkg::ST_FAIL;
    end
  end
  assign {tx_valid, tx_data, rsp_valid, rsp_data} = {tx_valid_r, tx_data_r, rsp_valid_r, rsp_data_r};
  assign {busy, done, fail} = {busy_r, done_r, fail_r};
  // Checks
  start_first_a: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r == abfc_pkg::ST_START && take |-> in_b == abfc_pkg::CH_BLK_START)
    else $error("block not opened by start character");
  end_char_a: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r == abfc_pkg::ST_END && take |-> in_b == (last_r ? 8'h03 : 8'h17))
    else $error("wrong block end character");
  lrc_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r == abfc_pkg::ST_LRC && take |-> ##1 st_r == abfc_pkg::ST_WAIT)
    else $error("no wait after checksum");
  block_size_a: assert property (@(posedge core_clk) disable iff (!resetn)
    bcnt_r <= 8'd255)
    else $error("block body too long");
  retry_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
    retry_r <= 3'd5)
    else $error("too many retries");
  ack_advance_a: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r == abfc_pkg::ST_WAIT && rx_ev && rx_b == abfc_pkg::CH_ACK && !last_r
    |=> blkno_r == $past(blkno_r) + 8'd1)
    else $error("block number not advanced after acknowledge");
  reply_ack_a: assert property (@(posedge core_clk) disable iff (!resetn)
    st_r == abfc_pkg::ST_REPLY |-> in_b == abfc_pkg::CH_ACK)
    else $error("reply not acknowledged");
  lead_first_a: assert property (@(posedge core_clk) disable iff (!resetn)
    take && st_r == abfc_pkg::ST_MSG && lead_r == 2'd2 && !replay_r |-> blkno_r == 8'd1)
    else $error("lead character outside first block");
  cmd_done_c: cover property (@(posedge core_clk) disable iff (!resetn) done_r);
  cmd_fail_c: cover property (@(posedge core_clk) disable iff (!resetn) fail_r);
  two_block_c: cover property (@(posedge core_clk) disable iff (!resetn) blkno_r == 8'd2);
endmodule

// ---- verilog/abfc_pkg.sv ----
// Package for the ASCII block frame command link host controller.
// Assumes a byte-wide UART outside this block and a 10 MHz core clock.
package abfc_pkg;
  // Transport and application control characters
  localparam logic [7:0] CH_BLK_START = 8'h02;
  localparam logic [7:0] CH_FRM_END = 8'h03;
  localparam logic [7:0] CH_BLK_END = 8'h17;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_NET_ID = 8'h40;
  localparam logic [7:0] CH_APP_OK = 8'h23;
  localparam logic [7:0] CH_APP_FAIL = 8'h21;
  localparam logic [7:0] CH_CTRL_LEAD = 8'h20;
  localparam logic [7:0] CH_QUERY_LEAD = 8'h3F;
  localparam logic [7:0] CH_DIGIT0 = 8'h30;
  localparam logic [7:0] LRC_INIT = 8'hFF;
  // Framing sizes
  localparam int BLK_MSG_MAX = 255;
  localparam int BLK_NUM_DIGITS = 3;
  localparam int MAX_RETRY = 5;
  // Answer timeout
  localparam int CLK_HZ = 10000000;
  localparam int ANS_TIMEOUT_MS = 2000;
  localparam int ANS_TIMEOUT_CYC = ANS_TIMEOUT_MS * (CLK_HZ / 1000);
  // Transmit states, Gray coded along the path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_NUM = 4'h3,
    ST_MSG = 4'h2,
    ST_END = 4'h6,
    ST_LRC = 4'h7,
    ST_WAIT = 4'h5,
    ST_RESP = 4'h4,
    ST_REPLY = 4'hC,
    ST_FAIL = 4'hD
  } abfc_state_e;
endpackage
